// *** rtl/sync_pipelined_sram_port.sv ***
// Purpose: Device side of a pipelined burst SRAM with synchronous control.
// Assumes: Pins cross from outside through two flops; rst_i is synchronous.
// Notes:   Read words pass a 32-word FIFO before driving the data pins.
// Summary of operation
// - Address captured at rising edge selects one memory location.
// - Each lane write select gates its own data byte and parity bit.
// - Lane write selects sampled only when clock qualify is low.
// - Write enable active low, sampled on each qualified load edge.
// - Step-or-load high on a qualified edge advances the burst counter unless deselected.
// - Step-or-load low on a qualified edge loads a fresh address when selected, else deselects.
// - Every synchronous input is captured on the rising edge.
// - Edges with clock qualify high are ignored except for popping read words to the pins.
// - Selected only when first and third low and second high.
// - Output enable low, synchronised and registered, lets the data pins drive.
// - Output enable high tristates data pins, treating them as inputs.
// - Tristate during write data and first cycle after deselect; pending read words still drive while deselected.
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_cfg.svh"

module sram_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = `FIFO_DEPTH_DEF
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0]      wr_q, wr_d, rd_q, rd_d;
  logic             push, pop;

  // Extra pointer bit separates full from empty
  always_comb begin
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    wr_d        = push ? wr_q + 1'b1 : wr_q;
    rd_d        = pop ? rd_q + 1'b1 : rd_q;
    in_ready_o  = (wr_q[PW-1:0] != rd_q[PW-1:0]) || (wr_q[PW] == rd_q[PW]);
    out_valid_o = (wr_q != rd_q);
    out_data_o  = mem_q[rd_q[PW-1:0]];
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_q[PW-1:0]] <= in_data_i;
    end
  end
endmodule // sram_fifo

module sync_pipelined_sram_port
  import sram_port_pkg::*;
#(
  parameter int ADDR_W    = `ADDR_W_DEF,
  parameter int LANES     = `LANES_DEF,
  parameter int LANE_BITS = `LANE_BITS_DEF,
  parameter int READ_LAT  = `READ_LAT_DEF,
  parameter int DEPTH     = `FIFO_DEPTH_DEF
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_i,
  input  wire logic [ADDR_W-1:0]          address_i,
  input  wire logic [LANES-1:0]           lane_write_select_n_i,
  input  wire logic                       write_enable_n_i,
  input  wire logic                       burst_step_or_load_i,
  input  wire logic                       clock_qualify_n_i,
  input  wire logic                       select_low_first_i,
  input  wire logic                       select_high_second_i,
  input  wire logic                       select_low_third_i,
  input  wire logic                       output_enable_n_i,
  input  wire logic [LANES*LANE_BITS-1:0] data_i,
  output logic      [LANES*LANE_BITS-1:0] data_o,
  output logic                            data_oe_o,
  output logic                            fifo_stall_o
);
  localparam int W = LANES * LANE_BITS;

  // Two-flop synchronisers; stage one feeds only stage two
  logic [ADDR_W-1:0] addr_s1_q, addr_s2_q;
  logic [LANES-1:0]  bw_s1_q, bw_s2_q;
  logic [6:0]        ctl_s1_q, ctl_s2_q, ctl_in;
  logic [W-1:0]      din_s1_q, din_s2_q;
  assign ctl_in = {write_enable_n_i, burst_step_or_load_i, clock_qualify_n_i,
                   select_low_first_i, select_high_second_i,
                   select_low_third_i, output_enable_n_i};

  always_ff @(posedge core_clk_i) begin
    addr_s1_q <= address_i;
    addr_s2_q <= addr_s1_q;
    bw_s1_q   <= lane_write_select_n_i;
    bw_s2_q   <= bw_s1_q;
    ctl_s1_q  <= ctl_in;
    ctl_s2_q  <= ctl_s1_q;
    din_s1_q  <= data_i;
    din_s2_q  <= din_s1_q;
  end

  logic we_n, adv, qual_n, ce1_n, ce2, ce3_n, oe_n;
  assign {we_n, adv, qual_n, ce1_n, ce2, ce3_n, oe_n} = ctl_s2_q;

  logic [LANES*LANE_BITS-1:0] mem_q [2**ADDR_W];
  logic [ADDR_W-1:0]     base_q, base_d;
  logic [`BURST_BITS-1:0] cnt_q, cnt_d;
  logic                  wr_q, wr_d;
  logic [LANES-1:0]      lanes_q, lanes_d;
  sel_state_t            st_q, st_d;
  logic                  qual, sel, fifo_ready, fifo_valid;
  logic [ADDR_W-1:0]     acc_addr;
  access_t               cmd;
  logic [READ_LAT-1:0]   rd_pipe_q, rd_pipe_d;
  logic [W-1:0]          rd_word_q [READ_LAT];
  logic [W-1:0]          wr_word_d;
  logic [W-1:0]          fifo_out;
  logic                  wr_phase_q, wr_phase_d;
  logic                  pop_now;

  // only qualified edges act; full FIFO also stalls every command, writes included
  assign qual = !qual_n && fifo_ready;
  assign sel = !ce1_n && ce2 && !ce3_n;
  // words exist only for selected reads; a deselect has no data phase
  assign pop_now = fifo_valid && !oe_n && !wr_phase_q && (st_q != ST_FIRST);

  // Command decode per qualified edge
  always_comb begin
    base_d    = base_q;
    cnt_d     = cnt_q;
    wr_d      = wr_q;
    lanes_d   = lanes_q;
    st_d      = st_q;
    cmd       = '0;
    acc_addr  = base_q;
    if (qual) begin
      if (adv && st_q != ST_DESEL) begin
        cnt_d    = cnt_q + 1'b1;
        acc_addr = {base_q[ADDR_W-1:`BURST_BITS], cnt_d};
        lanes_d  = ~bw_s2_q;
        cmd      = '{valid: 1'b1, write: wr_q, lanes: ~bw_s2_q,
                     addr: acc_addr};
        st_d     = ST_ACTIVE;
      end else if (!adv && sel) begin
        base_d   = addr_s2_q;
        cnt_d    = addr_s2_q[`BURST_BITS-1:0];
        acc_addr = addr_s2_q;
        wr_d     = !we_n;
        lanes_d  = ~bw_s2_q;
        cmd      = '{valid: 1'b1, write: !we_n, lanes: ~bw_s2_q,
                     addr: addr_s2_q};
        st_d     = (st_q == ST_DESEL) ? ST_FIRST : ST_ACTIVE;
      end else if (!adv) begin
        st_d     = ST_DESEL;
      end
    end
  end

  // read pipeline moves only on qualified cycles
  always_comb begin
    rd_pipe_d = rd_pipe_q;
    if (qual) begin
      rd_pipe_d = {rd_pipe_q[READ_LAT-2:0], cmd.valid && !cmd.write};
    end
    wr_phase_d = qual ? (cmd.valid && cmd.write) : wr_phase_q;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      base_q     <= '0;
      cnt_q      <= '0;
      wr_q       <= 1'b0;
      lanes_q    <= '0;
      st_q       <= ST_DESEL;
      rd_pipe_q  <= '0;
      wr_phase_q <= 1'b0;
    end else begin
      base_q     <= base_d;
      cnt_q      <= cnt_d;
      wr_q       <= wr_d;
      lanes_q    <= lanes_d;
      st_q       <= st_d;
      rd_pipe_q  <= rd_pipe_d;
      wr_phase_q <= wr_phase_d;
    end
  end

  // per-lane write gating of data and parity
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign wr_word_d[g*LANE_BITS +: LANE_BITS] = cmd.lanes[g] ?
        din_s2_q[g*LANE_BITS +: LANE_BITS] :
        mem_q[cmd.addr][g*LANE_BITS +: LANE_BITS];
    end
  endgenerate

  // Array write and read stage; no reset on storage
  always_ff @(posedge core_clk_i) begin
    if (qual && cmd.valid && cmd.write) begin
      mem_q[cmd.addr] <= wr_word_d;
    end
    if (qual) begin
      rd_word_q[0] <= mem_q[cmd.addr];
      for (int i = 1; i < READ_LAT; i++) begin
        rd_word_q[i] <= rd_word_q[i-1];
      end
    end
  end

  sram_fifo #(
    .WIDTH (W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (qual && rd_pipe_q[READ_LAT-1]),
    .in_ready_o  (fifo_ready),
    .in_data_i   (rd_word_q[READ_LAT-1]),
    .out_valid_o (fifo_valid),
    .out_ready_i (!oe_n && !wr_phase_q && (st_q != ST_FIRST)),
    .out_data_o  (fifo_out)
  );

  // Output pins registered; drive rules gate the enable
  logic [W-1:0] dout_q, dout_d;
  logic         oe_q, oe_d, stall_q;
  always_comb begin
    // Word changes only on a pop, so it stands while the pins float
    dout_d = pop_now ? fifo_out : dout_q;
    // enable only with output enable low and a popped word
    oe_d   = pop_now;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      dout_q  <= '0;
      oe_q    <= 1'b0;
      stall_q <= 1'b0;
    end else begin
      dout_q  <= dout_d;
      oe_q    <= oe_d;
      stall_q <= !fifo_ready;
    end
  end

  assign data_o       = dout_q;
  assign data_oe_o    = oe_q;
  assign fifo_stall_o = stall_q;
endmodule // sync_pipelined_sram_port
`default_nettype wire

// *** rtl/sram_port_cfg.svh ***
// Purpose: Constants for the pipelined burst SRAM port.
// Assumes: Included by bare name from the package and the top module.
// Notes:   Widths and depths are module parameters with these defaults; BURST_BITS is fixed.
`ifndef SRAM_PORT_CFG_SVH
`define SRAM_PORT_CFG_SVH
`define ADDR_W_DEF        10
`define LANES_DEF         4
`define LANE_BITS_DEF     9
`define READ_LAT_DEF      2
`define FIFO_DEPTH_DEF    32
`define BURST_BITS        2
`endif

// *** rtl/sram_port_pkg.sv ***
// Purpose: Types for the pipelined burst SRAM port.
// Assumes: Four byte lanes of eight data bits and one parity bit.
// Notes:   Widths in the structs follow the header defaults.
`include "sram_port_cfg.svh"
package sram_port_pkg;
  // Per-cycle command captured on a qualified edge
  typedef struct packed {
    logic                                     valid;
    logic                                     write;
    logic [`LANES_DEF-1:0]                    lanes;
    logic [`ADDR_W_DEF-1:0]                   addr;
  } access_t;

  // Read data leaving the pipeline
  typedef struct packed {
    logic [`LANES_DEF*`LANE_BITS_DEF-1:0]     data;
  } rd_word_t;

  typedef enum logic [1:0] {
    ST_DESEL  = 2'b00,
    ST_FIRST  = 2'b01,
    ST_ACTIVE = 2'b10
  } sel_state_t;
endpackage : sram_port_pkg

// *** tb/sram_port_chk.sv ***
// Purpose: Port assertions for the SRAM port
// Assumes: Pins cross two sync flops inside
// Notes:   Margins cover sync, read pipeline and output flops
`timescale 1ns/1ps
`default_nettype none
module sram_port_chk #(
  parameter int LANES     = 4,
  parameter int LANE_BITS = 9
) (
  input wire logic                       core_clk_i,
  input wire logic                       rst_i,
  input wire logic                       write_enable_n_i,
  input wire logic                       clock_qualify_n_i,
  input wire logic                       select_low_first_i,
  input wire logic                       select_high_second_i,
  input wire logic                       select_low_third_i,
  input wire logic                       output_enable_n_i,
  input wire logic [LANES*LANE_BITS-1:0] data_o,
  input wire logic                       data_oe_o,
  input wire logic                       fifo_stall_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  // Qualified edge seen at the pins
  logic q;
  assign q = !clock_qualify_n_i;

  reset_clear_a:
    assert property (disable iff (1'b0)
      rst_i |=> !data_oe_o && !fifo_stall_o)
    else $error("outputs not cleared by reset");
  oe_float_a:
    assert property (output_enable_n_i[*6] |-> !data_oe_o)
    else $error("drive while output enable high");
  desel_first_a:
    assert property ((q && select_low_first_i)[*8] |-> !data_oe_o)
    else $error("drive while first select high");
  desel_second_a:
    assert property ((q && !select_high_second_i)[*8] |-> !data_oe_o)
    else $error("drive while second select low");
  desel_third_a:
    assert property ((q && select_low_third_i)[*8] |-> !data_oe_o)
    else $error("drive while third select high");
  write_float_a:
    assert property ((q && !write_enable_n_i)[*6] |-> !data_oe_o)
    else $error("drive during write data phase");
  hold_data_a:
    assert property (output_enable_n_i[*6] |=> $stable(data_o))
    else $error("data word changed without a pop");
  stall_hold_a:
    assert property ((!q && output_enable_n_i)[*8] |=> $stable(fifo_stall_o))
    else $error("stall moved on unqualified edges");
endmodule // sram_port_chk
bind sync_pipelined_sram_port sram_port_chk #(
  .LANES(LANES), .LANE_BITS(LANE_BITS)) chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i),
  .write_enable_n_i(write_enable_n_i),
  .clock_qualify_n_i(clock_qualify_n_i),
  .select_low_first_i(select_low_first_i),
  .select_high_second_i(select_high_second_i),
  .select_low_third_i(select_low_third_i),
  .output_enable_n_i(output_enable_n_i), .data_o(data_o),
  .data_oe_o(data_oe_o), .fifo_stall_o(fifo_stall_o));
`default_nettype wire

// *** tb/sram_host_model.sv ***
// Purpose: Host controller driving the SRAM pins
// Assumes: Pins change on the falling edge only
// Notes:   Write data is held until the bench lets go
`timescale 1ns/1ps
`default_nettype none
module sram_host_model (
  input  wire logic core_clk_i,
  output logic [9:0]  addr_o,
  output logic [3:0]  lanes_n_o,
  output logic        we_n_o,
  output logic        step_o,
  output logic [2:0]  sel_o,
  output logic        qual_n_o,
  output logic [35:0] wdata_o,
  output logic        wdrive_o
);
  // Idle on the bus from time zero
  initial begin
    {addr_o, lanes_n_o, we_n_o, step_o} = {10'h000, 4'hF, 1'b1, 1'b0};
    {sel_o, qual_n_o, wdata_o, wdrive_o} = {3'b110, 1'b1, 36'h0, 1'b0};
  end
  // write low starts a write, load after deselect
  task automatic op(input logic [9:0] a, input logic w_n,
    input logic [3:0] l_n, input logic st, input logic [2:0] s,
    input logic qn);
    @(negedge core_clk_i);
    {addr_o, we_n_o, lanes_n_o, step_o, sel_o, qual_n_o} =
      {a, w_n, l_n, st, s, qn};
  endtask
  // Write data stays up through the data phase
  task automatic put(input logic [35:0] d, input logic on);
    wdata_o = d;
    wdrive_o = on;
  endtask
endmodule // sram_host_model
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: Scenario bench for the SRAM port
// Assumes: Host model drives every control pin except output enable, which the bench drives
// Notes:   Released bus shows the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic oe_n = 1'b1;
  int err_total = 0;
  int total_checks = 0;
  logic [9:0] a;
  logic [3:0] l_n;
  logic we_n, st, qn, wdr, oe, stall;
  logic [2:0] s;
  logic [35:0] wd, din, dout;
  localparam logic [2:0] SEL = 3'b010;
  localparam logic [2:0] DES = 3'b110;
  localparam logic [35:0] A = 36'h123456789, B = 36'hABCDEF012;
  localparam logic [35:0] AB = {A[35:27], B[26:18], A[17:9], B[8:0]};
  always #25 core_clk_i = ~core_clk_i;
  sram_host_model host (.core_clk_i(core_clk_i), .addr_o(a),
    .lanes_n_o(l_n), .we_n_o(we_n), .step_o(st), .sel_o(s),
    .qual_n_o(qn), .wdata_o(wd), .wdrive_o(wdr));
  // Wire level from both drivers
  assign din = oe ? dout : (wdr ? wd : ~wd);
  sync_pipelined_sram_port dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .address_i(a), .lane_write_select_n_i(l_n), .write_enable_n_i(we_n),
    .burst_step_or_load_i(st), .clock_qualify_n_i(qn),
    .select_low_first_i(s[2]), .select_high_second_i(s[1]),
    .select_low_third_i(s[0]), .output_enable_n_i(oe_n), .data_i(din),
    .data_o(dout), .data_oe_o(oe), .fifo_stall_o(stall));
  task automatic check(input string nm, input logic [35:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) host.op(10'h000, 1'b1, 4'hF, 1'b0, DES, 1'b0);
  endtask
  task automatic wr(input logic [9:0] ad, input logic [35:0] d,
    input logic [3:0] ln);
    host.put(d, 1'b1);
    host.op(ad, 1'b0, ln, 1'b0, SEL, 1'b0);
    idle(6);
    host.put(d, 1'b0);
  endtask
  // Waits on the drive enable, then compares the word
  task automatic rd(input logic [9:0] ad, input logic [35:0] exp);
    oe_n = 1'b0;
    host.op(ad, 1'b1, 4'hF, 1'b0, SEL, 1'b0);
    for (int i = 0; i < 30 && oe !== 1'b1; i++) idle(1);
    check("data_oe_o", {35'h0, oe}, 36'h1);
    check("data_o", dout, exp);
    idle(8);
  endtask
  task automatic t_lanes;
    wr(10'h005, A, 4'h0);
    wr(10'h005, B, 4'hA);
    rd(10'h005, AB);
  endtask
  task automatic t_burst;
    wr(10'h00C, B, 4'h0);
    host.put(A, 1'b1);
    host.op(10'h008, 1'b0, 4'h0, 1'b0, SEL, 1'b0);
    repeat (5) host.op(10'h3F0, 1'b0, 4'h0, 1'b1, SEL, 1'b0);
    idle(6);
    rd(10'h00B, A);
    rd(10'h00C, B);
  endtask
  task automatic t_qualify_select;
    logic [2:0] bad [3] = '{3'b110, 3'b000, 3'b011};
    wr(10'h014, A, 4'h0);
    host.put(B, 1'b1);
    repeat (8) host.op(10'h014, 1'b0, 4'h0, 1'b0, SEL, 1'b1);
    foreach (bad[i]) repeat (6) host.op(10'h014, 1'b0, 4'h0, 1'b0, bad[i], 1'b0);
    idle(6);
    rd(10'h014, A);
  endtask
  task automatic t_fill;
    oe_n = 1'b1;
    repeat (40) host.op(10'h005, 1'b1, 4'hF, 1'b0, SEL, 1'b0);
    repeat (10) host.op(10'h000, 1'b1, 4'hF, 1'b0, DES, 1'b1);
    check("fifo_stall_o", {35'h0, stall}, 36'h1);
    check("data_oe_o", {35'h0, oe}, 36'h0);
    oe_n = 1'b0;
    // Drain on unqualified edges; pops need no qualified cycle
    for (int i = 0; i < 150; i++) begin
      host.op(10'h000, 1'b1, 4'hF, 1'b0, DES, 1'b1);
      if (oe === 1'b1) check("data_o", dout, AB);
    end
    check("fifo_stall_o", {35'h0, stall}, 36'h0);
  endtask
  task automatic stop_test;
    $display("Checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge core_clk_i);
    rst_i = 1'b0;
    idle(4);
    t_lanes();
    t_burst();
    t_qualify_select();
    t_fill();
    stop_test();
  end
  // Watchdog well past the expected run
  initial begin
    #200000;
    err_total++;
    stop_test();
  end
endmodule // tb
`default_nettype wire
